// ---- tcpa_defs.vh ----
// tcpa_defs.vh: constants of the counter and pwm array
// assumes inclusion by bare name from every design file of the array
`ifndef TCPA_DEFS_VH
`define TCPA_DEFS_VH

// array shape
`define TCPA_NCH 32
`define TCPA_NWIDE 8
`define TCPA_WIDE_W 32
`define TCPA_NARROW_W 16
`define TCPA_DEAD_W 8
`define TCPA_CTRL_W 5

// global register byte offsets
`define TCPA_OFF_KILL 12'h000
`define TCPA_OFF_INT_TC 12'h004
`define TCPA_OFF_INT_CAP 12'h008
`define TCPA_OFF_MASK_TC 12'h00C
`define TCPA_OFF_MASK_CAP 12'h010
`define TCPA_OFF_RUN 12'h014
`define TCPA_OFF_SWCAP 12'h018

// channel window: base 0x400, 0x20 bytes per channel
`define TCPA_CH_SEL_BIT 10
`define TCPA_R_CTRL 3'h0
`define TCPA_R_PERIOD 3'h1
`define TCPA_R_CMP 3'h2
`define TCPA_R_DEAD 3'h3
`define TCPA_R_COUNT 3'h4
`define TCPA_R_CAPT 3'h5

// control fields
`define TCPA_C_EN 0
`define TCPA_C_ONESHOT 1
`define TCPA_C_KLVL_T 2
`define TCPA_C_KLVL_C 3
`define TCPA_C_CAPEN 4

// reset values and valid-bit masks
`define TCPA_CTRL_RST 5'h00
`define TCPA_PERIOD_RST 32'h0000FFFF
`define TCPA_CMP_RST 32'h00000000
`define TCPA_DEAD_RST 8'h00
`define TCPA_WIDE_MASK 32'hFFFFFFFF
`define TCPA_NARROW_MASK 32'h0000FFFF

`endif

// ---- tcpa_chan.v ----
// tcpa_chan.v: one up-counter with period, capture and compare
// assumes synchronous inputs and configuration held stable by the top
`timescale 1ns/1ps
`default_nettype none
`include "tcpa_defs.vh"

module tcpa_chan
#(
    parameter W = 16
)
(
    // clock and reset
    input wire clock,
    input wire arst_n,
    // configuration
    input wire enable,
    input wire one_shot,
    input wire cap_en,
    input wire [31:0] period,
    input wire [31:0] compare,
    // events
    input wire cap_in,
    input wire sw_cap,
    // state
    output wire [31:0] count_o,
    output wire [31:0] capture_o,
    output reg tc_evt_q,
    output reg cap_evt_q,
    output reg pwm_q,
    output reg run_q
);

reg [W-1:0] count_q;
reg [W-1:0] capture_q;
reg cap_in_q;
reg en_q;
wire [32:0] cnt_ext;
wire [32:0] cap_ext;
wire start;
wire at_per;
wire cap_trig;

assign start = enable & ~en_q;
assign at_per = run_q & (count_q == period[W-1:0]);
assign cap_trig = enable & ((cap_en & cap_in & ~cap_in_q) | sw_cap);
assign cnt_ext = {{(33-W){1'b0}}, count_q};
assign cap_ext = {{(33-W){1'b0}}, capture_q};
assign count_o = cnt_ext[31:0];
assign capture_o = cap_ext[31:0];

always @(posedge clock or negedge arst_n)
begin
    if (!arst_n)
    begin
        count_q <= {W{1'b0}};
        capture_q <= {W{1'b0}};
        cap_in_q <= 1'b0;
        en_q <= 1'b0;
        run_q <= 1'b0;
        tc_evt_q <= 1'b0;
        cap_evt_q <= 1'b0;
        pwm_q <= 1'b0;
    end
    else
    begin
        en_q <= enable;
        cap_in_q <= cap_in;
        tc_evt_q <= at_per;
        cap_evt_q <= cap_trig;
        if (!enable)
        begin
            run_q <= 1'b0;
            count_q <= {W{1'b0}};
        end
        else if (start)
            run_q <= 1'b1;
        else if (at_per)
        begin
            if (one_shot)
                run_q <= 1'b0;
            else
                count_q <= {W{1'b0}};
        end
        else if (run_q)
            count_q <= count_q + 1'b1;
        if (cap_trig)
            capture_q <= count_q;
        // duty = compare / (period + 1); low while stopped
        pwm_q <= run_q & enable & (count_q < compare[W-1:0]);
    end
end

endmodule
`default_nettype wire

// ---- tcpa_dead.v ----
// tcpa_dead.v: true/complement pair with dead band and kill override
// assumes kill is already synchronous to clock
`timescale 1ns/1ps
`default_nettype none
`include "tcpa_defs.vh"

module tcpa_dead
(
    // clock and reset
    input wire clock,
    input wire arst_n,
    // control
    input wire enable,
    input wire pwm,
    input wire [`TCPA_DEAD_W-1:0] dead,
    input wire kill,
    input wire kill_lvl_t,
    input wire kill_lvl_c,
    // pins
    output wire out_t,
    output wire out_c
);

reg pwm_q;
reg t_q;
reg c_q;
reg [`TCPA_DEAD_W-1:0] dly_q;
wire quiet;

// every edge of pwm leaves at least one cycle with both outputs low
assign quiet = (pwm == pwm_q) & (dly_q == {`TCPA_DEAD_W{1'b0}});

always @(posedge clock or negedge arst_n)
begin
    if (!arst_n)
    begin
        pwm_q <= 1'b0;
        t_q <= 1'b0;
        c_q <= 1'b0;
        dly_q <= {`TCPA_DEAD_W{1'b0}};
    end
    else
    begin
        pwm_q <= pwm;
        if (pwm != pwm_q)
            dly_q <= dead;
        else if (dly_q != {`TCPA_DEAD_W{1'b0}})
            dly_q <= dly_q - 1'b1;
        t_q <= enable & pwm & quiet;
        c_q <= enable & ~pwm & quiet;
    end
end

// kill bypasses the flops so the outputs take their kill levels in the same cycle
assign out_t = kill ? kill_lvl_t : t_q;
assign out_c = kill ? kill_lvl_c : c_q;

endmodule
`default_nettype wire

// ---- tcpa_top.v ----
// tcpa_top.v: array of 32 counters with pwm pairs, apb slave, interrupt
// assumes apb master on clock, capture and kill pins synchronous to it
//
// Notes on behaviour
// - there are 32 counters, the first eight 32 bits wide, the rest 16.
// - each counter has its own software period register.
// - at count equal period a counter stops or reloads, as set.
// - a capture event copies the current count into a capture register.
// - count below compare drives the pwm duty output of the counter.
// - each channel drives true and complement with a dead band between.
// - the kill input forces every output to its preset level at once.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tcpa_defs.vh"

module tcpa_top
(
    // clock and reset
    input wire clock,
    input wire arst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire [31:0] prdata,
    output wire pslverr,
    // event and fault pins
    input wire [`TCPA_NCH-1:0] cap_in,
    input wire kill_in,
    // pwm pins
    output wire [`TCPA_NCH-1:0] pwm_true,
    output wire [`TCPA_NCH-1:0] pwm_comp,
    // interrupt
    output wire irq
);

// ----------------------------------------------------------------
// configuration storage
// ----------------------------------------------------------------
reg [`TCPA_CTRL_W-1:0] ctrl_q [0:`TCPA_NCH-1];
reg [31:0] period_q [0:`TCPA_NCH-1];
reg [31:0] cmp_q [0:`TCPA_NCH-1];
reg [`TCPA_DEAD_W-1:0] dead_q [0:`TCPA_NCH-1];
reg [31:0] tc_st_q;
reg [31:0] cap_st_q;
reg [31:0] tc_mask_q;
reg [31:0] cap_mask_q;
reg [31:0] swcap_q;
reg [31:0] prdata_q;
reg err_q;
reg irq_q;
reg [31:0] rdata_d;
reg err_d;
integer kc;
integer kp;
integer km;
integer kd;

// ----------------------------------------------------------------
// channel state
// ----------------------------------------------------------------
wire [32*`TCPA_NCH-1:0] cnt_flat;
wire [32*`TCPA_NCH-1:0] cap_flat;
wire [`TCPA_NCH-1:0] tc_evt;
wire [`TCPA_NCH-1:0] cap_evt;
wire [`TCPA_NCH-1:0] pwm;
wire [`TCPA_NCH-1:0] run;

// ----------------------------------------------------------------
// address decode
// ----------------------------------------------------------------
wire setup;
wire wr_ok;
wire is_ch;
wire [4:0] chn;
wire [2:0] ri;
wire [31:0] clr_tc;
wire [31:0] clr_cap;

assign setup = psel & ~penable;
assign is_ch = paddr[`TCPA_CH_SEL_BIT];
assign chn = paddr[9:5];
assign ri = paddr[4:2];
assign pready = psel & penable;
assign pslverr = pready & err_q;
assign prdata = prdata_q;
assign irq = irq_q;
assign wr_ok = pready & pwrite & ~err_q;

// valid bits of a channel's period, compare, count and capture
function [31:0] ch_mask;
    input [4:0] n;
    begin
        if (n < `TCPA_NWIDE)
            ch_mask = `TCPA_WIDE_MASK;
        else
            ch_mask = `TCPA_NARROW_MASK;
    end
endfunction

// true when a write of the current access hits a global offset
function glb_hit;
    input [11:0] off;
    begin
        glb_hit = wr_ok & (paddr == off);
    end
endfunction

// true when a write of the current access hits field r of a channel
function ch_wr;
    input [2:0] r;
    begin
        ch_wr = wr_ok & is_ch & (ri == r);
    end
endfunction

assign clr_tc = glb_hit(`TCPA_OFF_INT_TC) ? pwdata : 32'h00000000;
assign clr_cap = glb_hit(`TCPA_OFF_INT_CAP) ? pwdata : 32'h00000000;

// ----------------------------------------------------------------
// read decode
// ----------------------------------------------------------------
always @*
begin
    rdata_d = 32'h00000000;
    err_d = 1'b0;
    if (paddr[1:0] != 2'h0 || paddr[11])
        err_d = 1'b1;
    else if (is_ch)
    begin
        if (ri == `TCPA_R_CTRL)
            rdata_d = {27'h0000000, ctrl_q[chn]};
        else if (ri == `TCPA_R_PERIOD)
            rdata_d = period_q[chn];
        else if (ri == `TCPA_R_CMP)
            rdata_d = cmp_q[chn];
        else if (ri == `TCPA_R_DEAD)
            rdata_d = {24'h000000, dead_q[chn]};
        else if (ri == `TCPA_R_COUNT)
            rdata_d = cnt_flat[chn*32 +: 32];
        else if (ri == `TCPA_R_CAPT)
            rdata_d = cap_flat[chn*32 +: 32];
        else
            err_d = 1'b1;
    end
    else if (paddr == `TCPA_OFF_KILL)
        rdata_d = {31'h00000000, kill_in};
    else if (paddr == `TCPA_OFF_INT_TC)
        rdata_d = tc_st_q;
    else if (paddr == `TCPA_OFF_INT_CAP)
        rdata_d = cap_st_q;
    else if (paddr == `TCPA_OFF_MASK_TC)
        rdata_d = tc_mask_q;
    else if (paddr == `TCPA_OFF_MASK_CAP)
        rdata_d = cap_mask_q;
    else if (paddr == `TCPA_OFF_RUN)
        rdata_d = run;
    else if (paddr == `TCPA_OFF_SWCAP)
        rdata_d = 32'h00000000;
    else
        err_d = 1'b1;
end

// ----------------------------------------------------------------
// bus response
// ----------------------------------------------------------------
// read data is sampled in the setup cycle, so every access has no wait
always @(posedge clock or negedge arst_n)
begin
    if (!arst_n)
    begin
        prdata_q <= 32'h00000000;
        err_q <= 1'b0;
    end
    else if (setup)
    begin
        prdata_q <= rdata_d;
        err_q <= err_d;
    end
end

// ----------------------------------------------------------------
// interrupt status
// ----------------------------------------------------------------
// a new event wins over a clear in the same cycle
always @(posedge clock or negedge arst_n)
begin
    if (!arst_n)
    begin
        tc_st_q <= 32'h00000000;
        cap_st_q <= 32'h00000000;
    end
    else
    begin
        tc_st_q <= (tc_st_q & ~clr_tc) | tc_evt;
        cap_st_q <= (cap_st_q & ~clr_cap) | cap_evt;
    end
end

// ----------------------------------------------------------------
// interrupt masks
// ----------------------------------------------------------------
always @(posedge clock or negedge arst_n)
begin
    if (!arst_n)
    begin
        tc_mask_q <= 32'h00000000;
        cap_mask_q <= 32'h00000000;
    end
    else
    begin
        if (glb_hit(`TCPA_OFF_MASK_TC))
            tc_mask_q <= pwdata;
        if (glb_hit(`TCPA_OFF_MASK_CAP))
            cap_mask_q <= pwdata;
    end
end

// ----------------------------------------------------------------
// interrupt output
// ----------------------------------------------------------------
// registered so the pin never glitches while status bits settle
always @(posedge clock or negedge arst_n)
begin
    if (!arst_n)
        irq_q <= 1'b0;
    else
        irq_q <= |(tc_st_q & tc_mask_q) | |(cap_st_q & cap_mask_q);
end

// ----------------------------------------------------------------
// software capture
// ----------------------------------------------------------------
// single-cycle strobe per written one, so nothing recaptures by itself
always @(posedge clock or negedge arst_n)
begin
    if (!arst_n)
        swcap_q <= 32'h00000000;
    else if (glb_hit(`TCPA_OFF_SWCAP))
        swcap_q <= pwdata;
    else
        swcap_q <= 32'h00000000;
end

// ----------------------------------------------------------------
// channel registers
// ----------------------------------------------------------------
// one process per field, so every array has a single driver
always @(posedge clock or negedge arst_n)
begin
    if (!arst_n)
    begin
        for (kc = 0; kc < `TCPA_NCH; kc = kc + 1)
            ctrl_q[kc] <= `TCPA_CTRL_RST;
    end
    else if (ch_wr(`TCPA_R_CTRL))
        ctrl_q[chn] <= pwdata[`TCPA_CTRL_W-1:0];
end

always @(posedge clock or negedge arst_n)
begin
    if (!arst_n)
    begin
        for (kp = 0; kp < `TCPA_NCH; kp = kp + 1)
            period_q[kp] <= `TCPA_PERIOD_RST;
    end
    else if (ch_wr(`TCPA_R_PERIOD))
        period_q[chn] <= pwdata & ch_mask(chn);
end

always @(posedge clock or negedge arst_n)
begin
    if (!arst_n)
    begin
        for (km = 0; km < `TCPA_NCH; km = km + 1)
            cmp_q[km] <= `TCPA_CMP_RST;
    end
    else if (ch_wr(`TCPA_R_CMP))
        cmp_q[chn] <= pwdata & ch_mask(chn);
end

always @(posedge clock or negedge arst_n)
begin
    if (!arst_n)
    begin
        for (kd = 0; kd < `TCPA_NCH; kd = kd + 1)
            dead_q[kd] <= `TCPA_DEAD_RST;
    end
    else if (ch_wr(`TCPA_R_DEAD))
        dead_q[chn] <= pwdata[`TCPA_DEAD_W-1:0];
end

// ----------------------------------------------------------------
// counter array
// ----------------------------------------------------------------
genvar i;
generate
    for (i = 0; i < `TCPA_NCH; i = i + 1)
    begin : g_ch
        // first channels are wide, the rest narrow
        localparam CW = (i < `TCPA_NWIDE) ? `TCPA_WIDE_W
            : `TCPA_NARROW_W;

        tcpa_chan
        #(
            .W(CW)
        )
        u_chan
        (
            .clock(clock),
            .arst_n(arst_n),
            .enable(ctrl_q[i][`TCPA_C_EN]),
            .one_shot(ctrl_q[i][`TCPA_C_ONESHOT]),
            .cap_en(ctrl_q[i][`TCPA_C_CAPEN]),
            .period(period_q[i]),
            .compare(cmp_q[i]),
            .cap_in(cap_in[i]),
            .sw_cap(swcap_q[i]),
            .count_o(cnt_flat[i*32 +: 32]),
            .capture_o(cap_flat[i*32 +: 32]),
            .tc_evt_q(tc_evt[i]),
            .cap_evt_q(cap_evt[i]),
            .pwm_q(pwm[i]),
            .run_q(run[i])
        );

        tcpa_dead u_dead
        (
            .clock(clock),
            .arst_n(arst_n),
            .enable(ctrl_q[i][`TCPA_C_EN]),
            .pwm(pwm[i]),
            .dead(dead_q[i]),
            .kill(kill_in),
            .kill_lvl_t(ctrl_q[i][`TCPA_C_KLVL_T]),
            .kill_lvl_c(ctrl_q[i][`TCPA_C_KLVL_C]),
            .out_t(pwm_true[i]),
            .out_c(pwm_comp[i])
        );
    end
endgenerate

endmodule
`default_nettype wire

// ---- tcpa_top_sva.sv ----
// tcpa_top_sva.sv: port checker of the counter array
// assumes a bind onto tcpa_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module tcpa_chk
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // pins
    input wire logic [31:0] cap_in,
    input wire logic kill_in,
    input wire logic [31:0] pwm_true,
    input wire logic [31:0] pwm_comp,
    input wire logic irq
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire acc = psel && penable;
    wire bad = paddr[1:0] != 2'h0 || paddr[11];
    a_ready_no_wait: assert property (pready == acc)
        else $error("pready differs from access phase");
    a_err_bad_addr: assert property (psel && !penable && bad ##1 acc
        |-> pslverr) else $error("bad address not refused");
    a_err_in_access: assert property (pslverr |-> pready)
        else $error("error outside access phase");
    a_narrow_upper: assert property (
        acc && !pwrite && paddr[11:10] == 2'h1 && paddr[9:5] >= 5'h08
        |-> prdata[31:16] == 16'h0000) else $error("narrow upper bits set");
    a_no_overlap: assert property (
        !kill_in |-> (pwm_true & pwm_comp) == 32'h00000000)
        else $error("true and complement high together");
    a_gap_first: assert property (!kill_in && !$past(kill_in)
        |-> (pwm_true & ~$past(pwm_true) & $past(pwm_comp)) == 0
        && (pwm_comp & ~$past(pwm_comp) & $past(pwm_true)) == 0)
        else $error("output rose with no dead gap");
    a_kill_hold: assert property (kill_in && $past(kill_in)
        && !$past(acc && pwrite) |-> $stable(pwm_true) && $stable(pwm_comp))
        else $error("outputs moved during kill");
    a_reset_quiet: assert property (disable iff (1'b0)
        !arst_n && !kill_in |-> pwm_true == 0 && pwm_comp == 0)
        else $error("outputs active in reset");
    c_kill: cover property (kill_in && pwm_true != 0);
    c_err: cover property (pslverr);
    c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// ---- tcpa_stage.sv ----
// tcpa_stage.sv: power stage and event source beside the array
// assumes the bench calls its tasks from the clock domain
`timescale 1ns/1ps
`default_nettype none
module tcpa_stage
(
    // clock
    input wire logic clock,
    // pwm pins
    input wire logic [31:0] pwm_true,
    input wire logic [31:0] pwm_comp,
    // event pins, idle low
    output logic [31:0] cap_in,
    output logic kill_in
);
    int hi_t = 0;
    int hi_c = 0;
    initial cap_in = 32'h00000000;
    initial kill_in = 1'b0;
    // two cycles high so the edge detector sees it
    task automatic pulse(input int n);
        @(posedge clock);
        cap_in[n] <= 1'b1;
        repeat (2) @(posedge clock);
        cap_in[n] <= 1'b0;
    endtask
    task automatic kill(input logic v);
        @(posedge clock);
        kill_in <= v;
    endtask
    // counts high cycles of one channel pair
    task automatic watch(input int n, input int cyc);
        hi_t = 0;
        hi_c = 0;
        repeat (cyc)
        begin
            @(posedge clock);
            hi_t += pwm_true[n];
            hi_c += pwm_comp[n];
        end
    endtask
endmodule
`default_nettype wire

// ---- test_timer_counter_pwm_array.sv ----
// test_timer_counter_pwm_array.sv: register level bench of the array
// assumes tcpa_top, tcpa_stage and tcpa_chk are compiled before it
`timescale 1ns/1ps
`default_nettype none
module test_timer_counter_pwm_array;
    logic clock, arst_n, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, c;
    wire logic pready, pslverr, irq, kill_in;
    wire logic [31:0] prdata, cap_in, pwm_true, pwm_comp;
    int miscompares = 0;
    int n_tests = 0;
    tcpa_top i_dut (.clock(clock), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .cap_in(cap_in), .kill_in(kill_in),
        .pwm_true(pwm_true), .pwm_comp(pwm_comp), .irq(irq));
    tcpa_stage i_stage (.clock(clock), .pwm_true(pwm_true),
        .pwm_comp(pwm_comp), .cap_in(cap_in), .kill_in(kill_in));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    function automatic logic [11:0] ca(input int n, input int r);
        return 12'h400 + 12'(n * 32 + r * 4);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // waits an edge first so release and next setup never share a step
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        check(rd, exp);
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        miscompares++;
        tally_and_finish;
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        rdchk(ca(0, 1), 32'h0000FFFF);
        rdchk(ca(0, 2), 32'h00000000);
        rdchk(ca(0, 0), 32'h00000000);
        apb(1'b0, 12'h01C, 32'h00000000);
        check(err, 1'b1);
        apb(1'b1, 12'h802, 32'h00000000);
        check(err, 1'b1);
        for (int n = 0; n < 32; n++)
            apb(1'b1, ca(n, 1), 32'hA5A50000 + n);
        for (int n = 0; n < 32; n++)
            rdchk(ca(n, 1), (32'hA5A50000 + n) &
                (n < 8 ? 32'hFFFFFFFF : 32'h0000FFFF));
        apb(1'b1, ca(1, 1), 32'h00000004);
        apb(1'b1, ca(1, 0), 32'h00000003);
        apb(1'b1, ca(2, 1), 32'h00000003);
        apb(1'b1, ca(2, 0), 32'h00000001);
        repeat (20) @(posedge clock);
        rdchk(ca(1, 4), 32'h00000004);
        rdchk(12'h014, 32'h00000004);
        rdchk(12'h004, 32'h00000006);
        apb(1'b0, ca(2, 4), 32'h00000000);
        check(rd <= 32'h00000003, 1'b1);
        apb(1'b1, 12'h004, 32'h00000002);
        apb(1'b0, 12'h004, 32'h00000000);
        check(rd[1], 1'b0);
        apb(1'b1, ca(2, 0), 32'h00000000);
        rdchk(ca(2, 4), 32'h00000000);
        rdchk(12'h014, 32'h00000000);
        apb(1'b1, ca(3, 1), 32'h0000FFFF);
        apb(1'b1, ca(3, 0), 32'h00000011);
        apb(1'b1, ca(5, 0), 32'h00000001);
        apb(1'b1, ca(4, 0), 32'h00000001);
        repeat (10) @(posedge clock);
        i_stage.pulse(3);
        i_stage.pulse(5);
        repeat (5) @(posedge clock);
        apb(1'b0, ca(3, 5), 32'h00000000);
        c = rd;
        apb(1'b0, ca(3, 4), 32'h00000000);
        check(rd > c && c > 0, 1'b1);
        rdchk(12'h008, 32'h00000008);
        apb(1'b1, 12'h018, 32'h00000010);
        // strobe, capture and status bit land on three successive edges
        repeat (2) @(posedge clock);
        rdchk(12'h008, 32'h00000018);
        check(irq, 1'b0);
        apb(1'b1, 12'h010, 32'h00000008);
        repeat (2) @(posedge clock);
        check(irq, 1'b1);
        apb(1'b1, 12'h010, 32'h00000000);
        repeat (2) @(posedge clock);
        check(irq, 1'b0);
        apb(1'b1, 12'h010, 32'h00000008);
        apb(1'b1, 12'h008, 32'h00000018);
        rdchk(12'h008, 32'h00000000);
        repeat (2) @(posedge clock);
        check(irq, 1'b0);
        // period 10, compare 5, gap 3: each side high 2 of 10 cycles
        apb(1'b1, ca(6, 1), 32'h00000009);
        apb(1'b1, ca(6, 2), 32'h00000005);
        apb(1'b1, ca(6, 3), 32'h00000002);
        apb(1'b1, ca(6, 0), 32'h00000001);
        repeat (30) @(posedge clock);
        i_stage.watch(6, 100);
        check(i_stage.hi_t >= 18 && i_stage.hi_t <= 22, 1'b1);
        check(i_stage.hi_c >= 18 && i_stage.hi_c <= 22, 1'b1);
        check(pwm_true[0] | pwm_comp[0], 1'b0);
        apb(1'b1, ca(6, 0), 32'h00000005);
        i_stage.kill(1'b1);
        #1;
        check({pwm_true[6], pwm_comp[6], pwm_true[7]}, 3'h4);
        rdchk(12'h000, 32'h00000001);
        i_stage.kill(1'b0);
        repeat (3) @(posedge clock);
        tally_and_finish;
    end
endmodule
bind tcpa_top tcpa_chk i_chk (.clock(clock), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cap_in(cap_in), .kill_in(kill_in),
    .pwm_true(pwm_true), .pwm_comp(pwm_comp), .irq(irq));
`default_nettype wire
